/* File: bos_pkg.sv */
/*
  Constants, opcodes and types of the bit-operation, skip and branch
  execution unit. Assumes a core that feeds one fetched instruction word
  per instruction cycle and owns the data memory.
*/
// Behaviour
// [RULE1] Set-bit, upper nibble 1000 then bit index, access bit and file address, forces the chosen bit of the addressed register to one.
// [RULE2] An access bit of zero addresses the access bank; an access bit of one takes the bank from the bank select register.
// [RULE3] With access bit zero, extended set enabled and file address 95 or less, indexed literal offset addressing is used.
// [RULE4] Skip-if-clear, nibble 1011, discards the fetched next instruction and runs a no-op when the tested bit is zero, taking two cycles.
// [RULE5] A taken skip over a two-word instruction lasts three cycles and over a three-word one four, each extra cycle a no-op.
// [RULE6] The relative branch loads the counter with its incremented value plus twice the signed offset and takes two cycles, the second a no-op flush.
// [RULE7] Set-bit and skip-if-clear leave the status flags alone; set-bit reads in the second quarter-cycle and writes in the fourth.
package bos_pkg;

  // ----------------------------------------
  // Opcodes
  // ----------------------------------------
  localparam logic [3:0] OP_SET_BIT = 4'h8;
  localparam logic [3:0] OP_SKIP_CLR = 4'hB;
  localparam logic [4:0] OP_REL_BRANCH = 5'h1A;

  // ----------------------------------------
  // Addressing
  // ----------------------------------------
  localparam logic [7:0] LIT_OFFSET_MAX = 8'h5F;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [5:0] ACCESS_HIGH_BANK = 6'h3F;
  localparam int ADDR_W = 14;
  localparam int PC_W = 21;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam logic [1:0] QUARTER_COUNT = 2'h3;
  localparam logic [1:0] FLUSH_ONE = 2'h1;
  localparam logic [1:0] FLUSH_TWO = 2'h2;
  localparam logic [1:0] FLUSH_THREE = 2'h3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    Q1 = 2'h0,
    Q2 = 2'h1,
    Q3 = 2'h2,
    Q4 = 2'h3
  } bos_quarter_t;

  typedef enum logic [1:0] {
    EX_NONE = 2'h0,
    EX_SET = 2'h1,
    EX_SKIP = 2'h2,
    EX_BRANCH = 2'h3
  } bos_kind_t;

endpackage : bos_pkg

/* File: bos_addr_gen.sv */
/*
  Effective data address generator for bit-oriented instructions.
  Assumes the bank select and index register values are stable in Q1.
*/
module bos_addr_gen
  import bos_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Operand fields
  input wire logic load,
  input wire logic accessBit,
  input wire logic [7:0] fileAddr,
  input wire logic extendedEnable,
  input wire logic [5:0] bankSelectReg,
  input wire logic [ADDR_W-1:0] indexBase,
  // Result
  output logic [ADDR_W-1:0] effAddr,
  output logic litOffsetMode
);

  logic [ADDR_W-1:0] next_effAddr;
  logic next_litOffset;

  // ----------------------------------------
  // Address selection
  // ----------------------------------------
  always_comb begin
    next_litOffset = 1'b0;
    if (accessBit) begin
      next_effAddr = {bankSelectReg, fileAddr}; // RULE2
    end else if (extendedEnable && fileAddr <= LIT_OFFSET_MAX) begin
      next_litOffset = 1'b1;
      next_effAddr = indexBase + {6'h00, fileAddr}; // RULE3
    end else if (fileAddr < ACCESS_SPLIT) begin
      next_effAddr = {6'h00, fileAddr}; // RULE2
    end else begin
      next_effAddr = {ACCESS_HIGH_BANK, fileAddr}; // RULE2
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      effAddr <= '0;
      litOffsetMode <= 1'b0;
    end else if (load) begin
      effAddr <= next_effAddr;
      litOffsetMode <= next_litOffset;
    end
  end

endmodule : bos_addr_gen

/* File: bos_exec.sv */
/*
  Execution unit for set-bit, skip-if-bit-clear and relative branch.
  Assumes the core presents instrWord at Q1 of each instruction cycle,
  tells the length in words of the following instruction, and returns
  read data from the data memory in the same quarter as the read strobe.
*/
module bos_exec
  import bos_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Instruction input
  input wire logic [15:0] instrWord,
  input wire logic [1:0] nextInstrWords,
  input wire logic [PC_W-1:0] pcIncremented,
  input wire logic extendedEnable,
  input wire logic [5:0] bankSelectReg,
  input wire logic [ADDR_W-1:0] indexBase,
  // Data memory
  input wire logic [7:0] readData,
  output logic [ADDR_W-1:0] memAddr,
  output logic memRead,
  output logic memWrite,
  output logic [7:0] writeData,
  // Program counter and pipeline
  output logic [PC_W-1:0] pcLoadValue,
  output logic pcLoad,
  output logic flushActive,
  output logic [1:0] quarter,
  output logic statusWrite,
  output logic litOffsetMode
);

  bos_quarter_t phase;
  bos_kind_t kind;
  logic [2:0] bitIndex;
  logic [10:0] branchOffset;
  logic [1:0] flushLeft;
  logic [7:0] readLatch;
  logic addrLoad;

  // ----------------------------------------
  // Decode function
  // ----------------------------------------
  function automatic bos_kind_t decode(input logic [15:0] w);
    if (w[15:12] == OP_SET_BIT) begin
      decode = EX_SET; // RULE1
    end else if (w[15:12] == OP_SKIP_CLR) begin
      decode = EX_SKIP; // RULE4
    end else if (w[15:11] == OP_REL_BRANCH) begin
      decode = EX_BRANCH; // RULE6
    end else begin
      decode = EX_NONE;
    end
  endfunction : decode

  assign addrLoad = (phase == Q1) && (flushLeft == 2'h0);

  bos_addr_gen u_addr (
    .clk(clk),
    .reset(reset),
    .load(addrLoad),
    .accessBit(instrWord[8]),
    .fileAddr(instrWord[7:0]),
    .extendedEnable(extendedEnable),
    .bankSelectReg(bankSelectReg),
    .indexBase(indexBase),
    .effAddr(memAddr),
    .litOffsetMode(litOffsetMode)
  );

  // ----------------------------------------
  // Quarter-cycle sequencer
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phase <= Q1;
      quarter <= 2'h0;
    end else begin
      unique case (phase)
        Q1: phase <= Q2;
        Q2: phase <= Q3;
        Q3: phase <= Q4;
        Q4: phase <= Q1;
      endcase
      quarter <= (phase == Q4) ? 2'h0 : 2'(phase + 2'h1);
    end
  end

  // ----------------------------------------
  // Decode and operand capture
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      kind <= EX_NONE;
      bitIndex <= 3'h0;
      branchOffset <= 11'h000;
    end else if (addrLoad) begin
      kind <= decode(instrWord);
      bitIndex <= instrWord[11:9];
      branchOffset <= instrWord[10:0];
    end else if (phase == Q1) begin
      kind <= EX_NONE;
    end
  end

  // ----------------------------------------
  // Data memory access
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      memRead <= 1'b0;
      memWrite <= 1'b0;
      writeData <= 8'h00;
      readLatch <= 8'h00;
    end else begin
      memRead <= 1'b0;
      memWrite <= 1'b0;
      if (addrLoad && (decode(instrWord) == EX_SET
          || decode(instrWord) == EX_SKIP)) begin
        memRead <= 1'b1; // RULE7
      end
      if (phase == Q2) begin
        readLatch <= readData;
      end
      if (phase == Q3 && kind == EX_SET) begin
        writeData <= readLatch | (8'h01 << bitIndex); // RULE1
        memWrite <= 1'b1; // RULE7
      end
    end
  end

  // ----------------------------------------
  // Skip and branch flush control
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flushLeft <= 2'h0;
      flushActive <= 1'b0;
      pcLoad <= 1'b0;
      pcLoadValue <= '0;
      statusWrite <= 1'b0;
    end else begin
      pcLoad <= 1'b0;
      statusWrite <= 1'b0; // RULE7
      if (phase == Q3 && kind == EX_SKIP && !readLatch[bitIndex]) begin
        unique case (nextInstrWords)
          2'h2: flushLeft <= FLUSH_TWO; // RULE5
          2'h3: flushLeft <= FLUSH_THREE; // RULE5
          default: flushLeft <= FLUSH_ONE; // RULE4
        endcase
      end else if (phase == Q3 && kind == EX_BRANCH) begin
        pcLoadValue <= PC_W'(pcIncremented
          + {{(PC_W-12){branchOffset[10]}}, branchOffset, 1'b0}); // RULE6
        pcLoad <= 1'b1;
        flushLeft <= FLUSH_ONE; // RULE6
      end else if (phase == Q4 && flushLeft != 2'h0) begin
        if (flushActive) begin
          flushLeft <= 2'(flushLeft - 2'h1); // RULE5
          flushActive <= (flushLeft != FLUSH_ONE);
        end else begin
          flushActive <= 1'b1; // RULE4
        end
      end
    end
  end

endmodule : bos_exec

/* File: bos_exec_sva.sv */
/*
  Port-level timing checker for bos_exec.
  Assumes it is bound to every bos_exec instance.
*/
module bos_exec_sva
  import bos_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Watched ports
  input wire logic [7:0] readData,
  input wire logic memRead,
  input wire logic memWrite,
  input wire logic [7:0] writeData,
  input wire logic pcLoad,
  input wire logic flushActive,
  input wire logic [1:0] quarter,
  input wire logic statusWrite
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  // ----------------------------------------
  // Flush length counter
  // ----------------------------------------
  int flushCnt;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      flushCnt <= 0;
    end else begin
      flushCnt <= flushActive ? flushCnt + 1 : 0;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_read_quarter: assert property (memRead |-> quarter == Q2)
    else $error("read strobe outside second quarter");
  chk_write_after_read: assert property (
    memWrite |-> quarter == Q4 && $past(memRead, 2))
    else $error("write strobe not two cycles after read");
  chk_write_sets_bit: assert property (
    memWrite |-> (writeData & $past(readData, 2)) == $past(readData, 2)
    && $countones(writeData ^ $past(readData, 2)) <= 1)
    else $error("write data is not read data with one bit set");
  chk_branch_flush: assert property (
    pcLoad |-> quarter == Q4 ##1 flushActive [*4])
    else $error("branch load not in Q4 or not flushed");
  chk_flush_cycle: assert property ($rose(flushActive) |-> flushActive [*4])
    else $error("flush shorter than one instruction cycle");
  chk_flush_bound: assert property (flushCnt <= 12)
    else $error("flush longer than three cycles");
  chk_status_kept: assert property (!statusWrite)
    else $error("status flags written");

  cover property (memWrite);
  cover property (pcLoad);
  cover property (flushCnt == 12);
endmodule : bos_exec_sva

bind bos_exec bos_exec_sva chk (.clk, .reset, .readData, .memRead,
  .memWrite, .writeData, .pcLoad, .flushActive, .quarter, .statusWrite);

/* File: bit_op_skip_branch_exec_test.sv */
/*
  Self-checking bench for bos_exec: set-bit, skip and branch words.
  Assumes the first edge after reset release is phase Q1.
*/
module bit_op_skip_branch_exec_test
  import bos_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, extendedEnable, memRead, memWrite, pcLoad;
  logic flushActive, statusWrite, litOffsetMode;
  logic [15:0] instrWord;
  logic [1:0] nextInstrWords, quarter;
  logic [PC_W-1:0] pcIncremented, pcLoadValue, gAddr, gData, gPc;
  logic [5:0] bankSelectReg;
  logic [ADDR_W-1:0] indexBase, memAddr;
  logic [7:0] readData, writeData;
  int failures, comparisons, flushN;

  bos_exec dut (.clk, .reset, .instrWord, .nextInstrWords, .pcIncremented,
    .extendedEnable, .bankSelectReg, .indexBase, .readData, .memAddr,
    .memRead, .memWrite, .writeData, .pcLoadValue, .pcLoad, .flushActive,
    .quarter, .statusWrite, .litOffsetMode);

  task automatic check(input logic [20:0] got, input logic [20:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Present one word and watch n instruction cycles
  task automatic exec(input logic [15:0] w, input logic [1:0] nw, input int n);
    instrWord = w;
    nextInstrWords = nw;
    flushN = 0;
    gAddr = '0;
    gData = '0;
    gPc = '0;
    repeat (4 * n) begin
      @(posedge clk);
      #1;
      if (memRead) gAddr = {7'h00, memAddr};
      if (memWrite) gData = {13'h0000, writeData};
      if (pcLoad) gPc = pcLoadValue;
      if (flushActive) flushN++;
      @(negedge clk);
      instrWord = 16'h0000;
    end
  endtask : exec

  task automatic testSet();
    bankSelectReg = 6'h05;
    readData = 8'h0A;
    exec(16'h8F12, 2'h1, 1);
    check(gAddr, 21'h000512);
    check(gData, 21'h00008A);
    readData = 8'hFE;
    exec(16'h8080, 2'h1, 1);
    check(gAddr, 21'h003F80);
    check(gData, 21'h0000FF);
    extendedEnable = 1'b1;
    readData = 8'h00;
    exec(16'h8605, 2'h1, 1);
    check(gAddr, 21'h000105);
    check({20'h00000, litOffsetMode}, 21'h000001);
    extendedEnable = 1'b0;
    $display("set-bit test done");
  endtask : testSet

  task automatic testSkip();
    readData = 8'hFB;
    for (int i = 1; i < 4; i++) begin
      exec(16'hB420, i[1:0], i + 1);
      check(21'(flushN), 21'(4 * i));
      check(gData, 21'h000000);
    end
    check(gAddr, 21'h000020);
    readData = 8'h04;
    exec(16'hB420, 2'h1, 1);
    check(21'(flushN), 21'h000000);
    $display("skip test done");
  endtask : testSkip

  task automatic testBranch();
    exec(16'hD7FD, 2'h1, 2);
    check(gPc, 21'h0000FA);
    check(21'(flushN), 21'h000004);
    exec(16'hD005, 2'h1, 2);
    check(gPc, 21'h00010A);
    $display("branch test done");
  endtask : testBranch

  task automatic summarize();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    reset = 1'b1;
    instrWord = 16'h0000;
    nextInstrWords = 2'h1;
    pcIncremented = 21'h000100;
    extendedEnable = 1'b0;
    bankSelectReg = 6'h00;
    indexBase = 14'h0100;
    readData = 8'h00;
    repeat (5) @(negedge clk);
    reset = 1'b0;
    testSet();
    testSkip();
    testBranch();
    summarize();
  end
endmodule : bit_op_skip_branch_exec_test
